// >>> uartx_pkg.sv
`default_nettype none
package uartx_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] ADDR_BAUD_DIV     = 8'h00;
	localparam logic [7:0] ADDR_LINE_MODE    = 8'h04;
	localparam logic [7:0] ADDR_CONTROL_MAIN = 8'h08;
	localparam logic [7:0] ADDR_STATUS_FIRST = 8'h0C;
	localparam logic [7:0] ADDR_CONTROL_EXT  = 8'h10;
	localparam logic [7:0] ADDR_DATA_PORT    = 8'h14;
	// line_control_ext fields
	localparam int EXT_RX_NINTH = 7;
	localparam int EXT_TX_NINTH = 6;
	localparam int EXT_PIN_DIR  = 5;
	localparam int EXT_OVR_IE   = 3;
	localparam int EXT_PF_IE    = 0;
	// line_mode fields
	localparam int MODE_LOOP   = 7;
	localparam int MODE_RECEIVE_SOURCE_SELECT   = 5;
	localparam int MODE_NINE   = 4;
	localparam int MODE_PAR_EN = 1;
	localparam int MODE_PAR_OD = 0;
	// line_control_main fields
	localparam int MAIN_TX_IE = 7;
	localparam int MAIN_RX_IE = 5;
	localparam int MAIN_TE    = 3;
	localparam int MAIN_RE    = 2;
	localparam int MAIN_SBK   = 0;
	// line_status_first fields
	localparam int STAT_TX_BUFFER_EMPTY = 7;
	localparam int STAT_TC   = 6;
	localparam int STAT_RX_BUFFER_FULL = 5;
	localparam int STAT_OVR  = 3;
	// reset values and timing
	localparam logic [12:0] BAUD_DIV_RESET = 13'h0004;
	localparam logic [7:0]  MODE_RESET     = 8'h00;
	localparam logic [7:0]  MAIN_RESET     = 8'h00;
	localparam logic [3:0]  FRAME_BITS_8   = 4'hA;
	localparam logic [3:0]  FRAME_BITS_9   = 4'hB;
	localparam logic [3:0]  RT_LAST        = 4'hF;
	localparam logic [3:0]  RT_SAMPLE_A    = 4'h7;
	localparam logic [3:0]  RT_SAMPLE_B    = 4'h8;
	localparam logic [3:0]  RT_SAMPLE_C    = 4'h9;
	localparam logic [3:0]  RT_START_A     = 4'h2;
	localparam logic [3:0]  RT_START_B     = 4'h4;
	localparam logic [3:0]  RT_START_C     = 4'h6;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b01,
		RX_FRAME = 2'b10
	} uartx_rx_state_type;

	typedef struct packed {
		logic [12:0]        baud_div;
		logic [7:0]         line_mode;
		logic [7:0]         control_main;
		logic               tx_ninth_bit;
		logic               single_wire_pin_dir;
		logic [3:0]         err_irq_en;
		logic [12:0]        baud_cnt;
		logic [3:0]         tx_rt;
		logic [7:0]         tx_buf;
		logic               tx_buf_ninth;
		logic               tx_buffer_empty;
		logic               tx_complete;
		logic [10:0]        tx_shift;
		logic [3:0]         tx_left;
		logic               tx_busy;
		logic               idle_queued;
		logic               break_queued;
		logic [1:0]         rx_sync;
		logic [1:0]         pin_sync;
		uartx_rx_state_type rx_state;
		logic [2:0]         rx_hist;
		logic [3:0]         rx_rt;
		logic [3:0]         rx_bitn;
		logic [1:0]         rx_zeros;
		logic [1:0]         rx_smp;
		logic               rx_prev;
		logic               rx_noise;
		logic [8:0]         rx_shift;
		logic [7:0]         rx_data;
		logic               rx_ninth_bit;
		logic               rx_buffer_full;
		logic               overrun_flag;
		logic               noise_flag;
		logic               framing_error_flag;
		logic               parity_error_flag;
		logic [4:0]         armed;
		logic [31:0]        prdata;
		logic               pready;
		logic               pslverr;
		logic               serial_out_pin;
		logic               serial_out_oe;
		logic               tx_irq;
		logic               rx_irq;
		logic               err_irq;
	} uartx_state_type;
endpackage
`default_nettype wire

// >>> uartx_top.sv
// Our own choices: the register addresses and the APB slave port.
`default_nettype none
module uartx_top
	import uartx_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        serial_in_pin,
	input  wire logic        serial_out_pin_in,
	output var  logic        serial_out_pin,
	output var  logic        serial_out_oe,
	output var  logic        tx_irq,
	output var  logic        rx_irq,
	output var  logic        err_irq
);
	uartx_state_type st;
	uartx_state_type next_st;

	logic       take;
	logic       wr;
	logic       rd;
	logic       tick;
	logic       bit_tick;
	logic       nine;
	logic       single_wire;
	logic       rx_in;
	logic       majority;
	logic       par_bad;
	logic       break_seen;
	logic [3:0] frame_len;
	logic [3:0] stop_index;
	logic [7:0] status_value;
	logic [7:0] ext_value;
	logic [7:0] data_word;
	logic       data_ninth;
	logic [1:0] zero_sum;

	// next state: bus slave, baud generator, transmitter, receiver
	always_comb
	begin
		next_st = st;
		take = psel && penable && !st.pready;
		wr = take && pwrite;
		rd = take && !pwrite;
		nine = st.line_mode[MODE_NINE];
		single_wire = st.line_mode[MODE_LOOP] && st.line_mode[MODE_RECEIVE_SOURCE_SELECT];
		frame_len = nine ? FRAME_BITS_9 : FRAME_BITS_8;
		stop_index = nine ? 4'h9 : 4'h8;
		status_value = {st.tx_buffer_empty, st.tx_complete, st.rx_buffer_full, 1'b0,
			st.overrun_flag, st.noise_flag, st.framing_error_flag, st.parity_error_flag};
		ext_value = {st.rx_ninth_bit, st.tx_ninth_bit, st.single_wire_pin_dir,
			1'b0, st.err_irq_en};
		majority = 1'b0;
		par_bad = 1'b0;
		break_seen = 1'b0;
		data_word = 8'h00;
		data_ninth = 1'b0;
		zero_sum = 2'b00;

		// two-stage synchronisers for the pins
		next_st.rx_sync = {st.rx_sync[0], serial_in_pin};
		next_st.pin_sync = {st.pin_sync[0], serial_out_pin_in};
		if (single_wire)
		begin
			rx_in = st.pin_sync[1];
		end
		else if (st.line_mode[MODE_LOOP])
		begin
			rx_in = st.serial_out_pin;
		end
		else
		begin
			rx_in = st.rx_sync[1];
		end

		// bus answer: registered data, ready one cycle after the access starts
		next_st.pready = take;
		next_st.pslverr = 1'b0;
		if (!take)
		begin
			next_st.prdata = 32'h0000_0000;
		end
		else
		begin
			unique case (paddr)
				ADDR_BAUD_DIV:     next_st.prdata = {19'h00000, st.baud_div};
				ADDR_LINE_MODE:    next_st.prdata = {24'h000000, st.line_mode};
				ADDR_CONTROL_MAIN: next_st.prdata = {24'h000000, st.control_main};
				ADDR_STATUS_FIRST: next_st.prdata = {24'h000000, status_value};
				ADDR_CONTROL_EXT:  next_st.prdata = {24'h000000, ext_value};
				ADDR_DATA_PORT:    next_st.prdata = {24'h000000, st.rx_data};
				default:
				begin
					next_st.prdata = 32'h0000_0000;
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		// register writes and their side effects
		if (wr && paddr == ADDR_BAUD_DIV)
			next_st.baud_div = pwdata[12:0];
		if (wr && paddr == ADDR_LINE_MODE)
			next_st.line_mode = pwdata[7:0];
		if (wr && paddr == ADDR_CONTROL_MAIN)
		begin
			next_st.control_main = pwdata[7:0];
			if (pwdata[MAIN_TE] && !st.control_main[MAIN_TE])
			begin
				next_st.idle_queued = 1'b1;
				next_st.tx_complete = 1'b0;
			end
			if (pwdata[MAIN_SBK] && !st.control_main[MAIN_SBK])
			begin
				next_st.break_queued = 1'b1;
				next_st.tx_complete = 1'b0;
			end
		end
		if (wr && paddr == ADDR_CONTROL_EXT)
		begin
			next_st.tx_ninth_bit = pwdata[EXT_TX_NINTH];
			next_st.single_wire_pin_dir = pwdata[EXT_PIN_DIR];
			next_st.err_irq_en = pwdata[EXT_OVR_IE:EXT_PF_IE];
		end
		if (wr && paddr == ADDR_DATA_PORT)
		begin
			next_st.tx_buf = pwdata[7:0];
			next_st.tx_buf_ninth = st.tx_ninth_bit;
			next_st.tx_buffer_empty = 1'b0;
			next_st.tx_complete = 1'b0;
		end

		// status read arms the flags that are set now
		if (rd && paddr == ADDR_STATUS_FIRST)
		begin
			next_st.armed = {st.rx_buffer_full, st.overrun_flag, st.noise_flag,
				st.framing_error_flag, st.parity_error_flag};
		end
		// data read clears the armed flags; later sets override below
		if (rd && paddr == ADDR_DATA_PORT)
		begin
			next_st.rx_buffer_full = st.rx_buffer_full && !st.armed[4];
			next_st.overrun_flag = st.overrun_flag && !st.armed[3];
			next_st.noise_flag = st.noise_flag && !st.armed[2];
			next_st.framing_error_flag = st.framing_error_flag && !st.armed[1];
			next_st.parity_error_flag = st.parity_error_flag && !st.armed[0];
			next_st.armed = 5'h00;
		end

		// shared 16x baud generator on the bus clock
		tick = 1'b0;
		if (st.baud_div != 13'h0000)
		begin
			if (st.baud_cnt == 13'h0000)
			begin
				tick = 1'b1;
				next_st.baud_cnt = st.baud_div - 13'h0001;
			end
			else
			begin
				next_st.baud_cnt = st.baud_cnt - 13'h0001;
			end
		end
		bit_tick = tick && st.tx_rt == RT_LAST;
		if (tick)
		begin
			next_st.tx_rt = st.tx_rt + 4'h1;
		end

		// transmit shifter: shift, then reload when free on the bit tick
		if (bit_tick)
		begin
			if (st.tx_busy)
			begin
				next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
				next_st.tx_left = st.tx_left - 4'h1;
				next_st.tx_busy = st.tx_left != 4'h1;
			end
			if (!next_st.tx_busy)
			begin
				next_st.tx_left = frame_len;
				if (st.break_queued)
				begin
					next_st.tx_shift = 11'h000;
					next_st.tx_busy = 1'b1;
					next_st.break_queued = st.control_main[MAIN_SBK];
				end
				else if (st.idle_queued)
				begin
					next_st.tx_shift = 11'h7FF;
					next_st.tx_busy = 1'b1;
					next_st.idle_queued = 1'b0;
				end
				else if (!st.tx_buffer_empty && st.control_main[MAIN_TE])
				begin
					if (nine)
					begin
						next_st.tx_shift = {1'b1, st.tx_buf_ninth, st.tx_buf, 1'b0};
					end
					else
					begin
						next_st.tx_shift = {2'b11, st.tx_buf, 1'b0};
					end
					next_st.tx_busy = 1'b1;
					next_st.tx_buffer_empty = 1'b1;
				end
				else if (st.tx_busy)
				begin
					next_st.tx_complete = 1'b1;
				end
			end
		end

		// pin ownership: held while enabled, busy or an idle or break is still queued; single-wire mode follows the direction bit
		next_st.serial_out_pin = next_st.tx_busy ? next_st.tx_shift[0] : 1'b1;
		if (next_st.control_main[MAIN_TE] || next_st.tx_busy || next_st.idle_queued
			|| next_st.break_queued)
		begin
			next_st.serial_out_oe = single_wire ? next_st.single_wire_pin_dir : 1'b1;
		end
		else
		begin
			next_st.serial_out_oe = 1'b0;
		end

		// receiver on the 16x sample tick
		if (!st.control_main[MAIN_RE])
		begin
			next_st.rx_state = RX_IDLE;
			next_st.rx_hist = 3'b000;
		end
		else if (tick)
		begin
			unique case (st.rx_state)
				RX_IDLE:
				begin
					next_st.rx_hist = {st.rx_hist[1:0], rx_in};
					if (st.rx_hist == 3'b111 && !rx_in)
					begin
						next_st.rx_state = RX_FRAME;
						next_st.rx_rt = 4'h1;
						next_st.rx_bitn = 4'h0;
						next_st.rx_zeros = 2'b00;
						next_st.rx_noise = 1'b0;
					end
					next_st.rx_prev = rx_in;
				end
				RX_FRAME:
				begin
					next_st.rx_rt = st.rx_rt + 4'h1;
					next_st.rx_prev = rx_in;
					if (st.rx_bitn == 4'h0)
					begin
						// start bit verification at RT3, RT5, RT7
						if (st.rx_rt == RT_START_A || st.rx_rt == RT_START_B
							|| st.rx_rt == RT_START_C)
						begin
							next_st.rx_zeros = st.rx_zeros + {1'b0, !rx_in};
							next_st.rx_noise = st.rx_noise | rx_in;
						end
						zero_sum = st.rx_zeros + {1'b0, !rx_in};
						if (st.rx_rt == RT_START_C && zero_sum < 2'h2)
						begin
							next_st.rx_state = RX_IDLE;
							next_st.rx_hist = 3'b000;
						end
					end
					else if (st.rx_prev && !rx_in)
						next_st.rx_rt = 4'h1;
					if (st.rx_rt == RT_SAMPLE_A)
						next_st.rx_smp[0] = rx_in;
					if (st.rx_rt == RT_SAMPLE_B)
						next_st.rx_smp[1] = rx_in;
					if (st.rx_rt == RT_SAMPLE_C)
					begin
						majority = (st.rx_smp[0] & st.rx_smp[1]) | (st.rx_smp[0] & rx_in)
							| (st.rx_smp[1] & rx_in);
						if (!(st.rx_smp[0] == rx_in && st.rx_smp[1] == rx_in))
							next_st.rx_noise = 1'b1;
						if (st.rx_bitn != 4'h0 && st.rx_bitn <= stop_index)
							next_st.rx_shift = {majority, st.rx_shift[8:1]};
						if (st.rx_bitn == stop_index + 4'h1)
						begin
							// stop bit: hand the character to the buffer
							data_word = nine ? st.rx_shift[7:0] : st.rx_shift[8:1];
							data_ninth = nine ? st.rx_shift[8] : st.rx_ninth_bit;
							par_bad = st.line_mode[MODE_PAR_EN] && ((^data_word)
								^ (nine & data_ninth) ^ st.line_mode[MODE_PAR_OD]);
							break_seen = !majority && data_word == 8'h00
								&& !(nine && data_ninth);
							if (st.rx_buffer_full)
							begin
								next_st.overrun_flag = 1'b1;
							end
							else if (!st.framing_error_flag)
							begin
								next_st.rx_data = data_word;
								next_st.rx_ninth_bit = data_ninth;
								next_st.rx_buffer_full = 1'b1;
								next_st.noise_flag = next_st.rx_noise;
								next_st.framing_error_flag = !majority;
								next_st.parity_error_flag = par_bad;
							end
							next_st.rx_state = RX_IDLE;
							next_st.rx_hist = break_seen ? 3'b000 : 3'b111;
						end
					end
					if (st.rx_rt == RT_LAST)
						next_st.rx_bitn = st.rx_bitn + 4'h1;
				end
				default:
				begin
					next_st.rx_state = RX_IDLE;
				end
			endcase
		end

		// request outputs
		next_st.tx_irq = st.control_main[MAIN_TX_IE] && next_st.tx_buffer_empty;
		next_st.rx_irq = st.control_main[MAIN_RX_IE] && next_st.rx_buffer_full;
		next_st.err_irq = (st.err_irq_en[3] && next_st.overrun_flag)
			|| (st.err_irq_en[2] && next_st.noise_flag)
			|| (st.err_irq_en[1] && next_st.framing_error_flag)
			|| (st.err_irq_en[0] && next_st.parity_error_flag);
	end

	// state register with clock enable
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st <= '0;
			st.baud_div <= BAUD_DIV_RESET;
			st.line_mode <= MODE_RESET;
			st.control_main <= MAIN_RESET;
			st.tx_buffer_empty <= 1'b1;
			st.tx_complete <= 1'b1;
			st.tx_shift <= 11'h7FF;
			st.rx_state <= RX_IDLE;
			st.serial_out_pin <= 1'b1;
		end
		else if (clk_en)
		begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign serial_out_pin = st.serial_out_pin;
	assign serial_out_oe = st.serial_out_oe;
	assign tx_irq = st.tx_irq;
	assign rx_irq = st.rx_irq;
	assign err_irq = st.err_irq;
endmodule
`default_nettype wire

// >>> uartx_monitor.sv
`default_nettype none
module uartx_monitor
	import uartx_pkg::*;
(
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        serial_out_pin,
	input wire logic        serial_out_oe,
	input wire logic        tx_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	// everything sampled on mclk, quiet during reset
	default clocking mon_cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	answer_next_a: assert property (psel && penable && !pready && clk_en |=> pready)
		else $error("access not answered in the next cycle");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside an answer");
	err_reads_zero_a: assert property (pslverr |-> prdata == 32'h0)
		else $error("refused access returned data");
	idle_bus_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero between answers");
	ext_bit_four_a: assert property (pready && !pwrite && paddr == ADDR_CONTROL_EXT
		|-> prdata[31:8] == 24'h0 && !prdata[4])
		else $error("unused extension bits read nonzero");
	released_high_a: assert property (!serial_out_oe |-> serial_out_pin)
		else $error("released transmit pin not high");
	reset_values_a: assert property (!$past(reset_n)
		|-> !pready && serial_out_pin && !serial_out_oe && !tx_irq)
		else $error("outputs off their reset values");
	freeze_a: assert property (!clk_en |=> $stable(serial_out_pin)
		&& $stable(serial_out_oe) && $stable(pready))
		else $error("outputs moved while clock enable low");
endmodule
bind uartx_top uartx_monitor uartx_monitor_inst (.mclk(mclk), .reset_n(reset_n),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_out_pin(serial_out_pin),
	.serial_out_oe(serial_out_oe), .tx_irq(tx_irq));
`default_nettype wire

// >>> uartx_peer.sv
`default_nettype none
module uartx_peer #(
	parameter int BIT = 16
) (
	input  wire logic mclk,
	input  wire logic txd,
	input  wire logic nine,
	output var  logic rxd
);
	timeunit 1ns;
	timeprecision 100ps;
	int rxq[$];
	int lows[$];
	int cyc;
	int fall_at;
	int run;
	initial rxd = 1'b1;
	// low-run meter for break lengths
	always @(posedge mclk)
	begin
		cyc++;
		if (txd === 1'b0)
			run++;
		else if (run > 0)
		begin
			lows.push_back(run);
			run = 0;
		end
	end
	// frame decoder: centre samples, data LSB first, stop on top
	initial
	forever
	begin : dec
		int v;
		@(negedge txd);
		fall_at = cyc;
		repeat (BIT / 2) @(posedge mclk);
		v = 0;
		for (int i = 0; i < 9 + nine; i++)
		begin
			repeat (BIT) @(posedge mclk);
			v |= (txd === 1'b1) << i;
		end
		rxq.push_back(v);
	end
	// remote sender: start 0, data LSB first, chosen stop level
	task automatic send(input logic [8:0] d, input logic stop);
		logic [11:0] f;
		f = 12'(d) << 1;
		f[9 + nine] = stop;
		for (int k = 0; k < 10 + nine; k++)
		begin
			rxd <= f[k];
			repeat (BIT) @(posedge mclk);
		end
		rxd <= 1'b1;
		// one idle cycle so back-to-back frames never assign rxd twice in a step
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

// >>> uartx_top_tb.sv
`default_nettype none
module uartx_top_tb
	import uartx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serial_in_pin;
	logic        serial_out_pin;
	logic        serial_out_oe;
	logic        tx_irq;
	logic        rx_irq;
	logic        err_irq;
	logic        nine = 1'b0;
	logic        line;
	logic [31:0] rdat;
	int          mismatches = 0;
	int          checks_done = 0;
	int          expq[$];
	int          t0;
	int          ebit[3] = '{1, 3, 0};
	// released transmit pin is pulled high
	assign line = serial_out_oe ? serial_out_pin : 1'b1;
	initial
	forever
		#12.5 mclk = ~mclk;
	uartx_top uartx_top_inst (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
		.serial_out_pin_in(line), .serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
	uartx_peer uartx_peer_inst (.mclk(mclk), .txd(line), .nine(nine), .rxd(serial_in_pin));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one APB transfer: setup, access held until pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
			@(posedge mclk);
		while (pready !== 1'b1 && ++n < 40);
		if (pready !== 1'b1)
			mismatches++;
		rdat = prdata;
		check("pslverr", {31'h0, pslverr}, {31'h0, a > ADDR_DATA_PORT});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		check(what, rdat, exp);
	endtask
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do
			apb(ADDR_STATUS_FIRST, 1'b0, 32'h0);
		while (rdat[b] !== 1'b1 && ++n < 200);
		if (rdat[b] !== 1'b1)
			mismatches++;
	endtask
	// three random bytes, waiting for room each time, then frame compare
	task automatic send_frames(input int top);
		int d;
		for (int i = 0; i < 3; i++)
		begin
			wait_flag(STAT_TX_BUFFER_EMPTY);
			check("tx request", {31'h0, tx_irq}, 32'h1);
			d = $urandom & 32'hFF;
			expq.push_back(d | top);
			apb(ADDR_DATA_PORT, 1'b1, d);
		end
		wait_flag(STAT_TC);
		foreach (expq[i])
			check("tx frame", uartx_peer_inst.rxq[i], expq[i]);
		expq.delete();
		uartx_peer_inst.rxq.delete();
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// hang guard: the sequence needs well under 15000 cycles
	initial
	begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		end_of_test();
	end
	initial
	begin
		void'($urandom(32'h6abe));
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd("ext reset", ADDR_CONTROL_EXT, 32'h0);
		rd("status reset", ADDR_STATUS_FIRST, 32'hC0);
		apb(8'h18, 1'b1, 32'hFF);
		apb(ADDR_CONTROL_EXT, 1'b1, 32'hFF);
		rd("ext fields", ADDR_CONTROL_EXT, 32'h6F);
		apb(ADDR_CONTROL_EXT, 1'b0 + 1'b1, 32'h0);
		apb(ADDR_BAUD_DIV, 1'b1, 32'h1);
		clk_en <= 1'b0;
		repeat (5) @(posedge mclk);
		clk_en <= 1'b1;
		rd("baud", ADDR_BAUD_DIV, 32'h1);
		// enable: preamble first, data waits behind it
		apb(ADDR_CONTROL_MAIN, 1'b1, 32'h88);
		t0 = uartx_peer_inst.cyc;
		expq.push_back(32'h100 | 32'h42);
		apb(ADDR_DATA_PORT, 1'b1, 32'h42);
		rd("status after write", ADDR_STATUS_FIRST, 32'h0);
		wait_flag(STAT_TX_BUFFER_EMPTY);
		check("preamble", {31'h0, uartx_peer_inst.cyc - t0 >= 150}, 32'h1);
		send_frames(32'h100);
		nine <= 1'b1;
		apb(ADDR_LINE_MODE, 1'b1, 32'h10);
		apb(ADDR_CONTROL_EXT, 1'b1, 32'h40);
		send_frames(32'h300);
		// single break in 9-bit mode, held break in 8-bit mode
		for (int k = 0; k < 2; k++)
		begin
			uartx_peer_inst.lows.delete();
			// baud held still so the break loads only after the chosen clear
			apb(ADDR_BAUD_DIV, 1'b1, 32'h0);
			apb(ADDR_CONTROL_MAIN, 1'b1, 32'h89);
			if (k == 0)
				apb(ADDR_CONTROL_MAIN, 1'b1, 32'h88);
			apb(ADDR_BAUD_DIV, 1'b1, 32'h1);
			repeat (40) @(posedge mclk);
			apb(ADDR_CONTROL_MAIN, 1'b1, 32'h88);
			for (int n = 0; n < 900 && uartx_peer_inst.lows.size() == 0; n++)
				@(posedge mclk);
			check("break length", uartx_peer_inst.lows[0], k ? 320 : 176);
			nine <= 1'b0;
			apb(ADDR_LINE_MODE, 1'b1, 32'h0);
		end
		// enable toggle queues idle and keeps the pin
		uartx_peer_inst.rxq.delete();
		apb(ADDR_DATA_PORT, 1'b1, 32'hA5);
		wait_flag(STAT_TX_BUFFER_EMPTY);
		apb(ADDR_CONTROL_MAIN, 1'b1, 32'h80);
		apb(ADDR_CONTROL_MAIN, 1'b1, 32'h88);
		t0 = uartx_peer_inst.cyc;
		check("pin kept", {31'h0, serial_out_oe}, 32'h1);
		apb(ADDR_DATA_PORT, 1'b1, 32'h5A);
		wait_flag(STAT_TC);
		check("queued idle", {31'h0, uartx_peer_inst.fall_at - t0 >= 160}, 32'h1);
		// disable mid-frame: pin held until the frame ends
		apb(ADDR_DATA_PORT, 1'b1, 32'h3C);
		wait_flag(STAT_TX_BUFFER_EMPTY);
		apb(ADDR_CONTROL_MAIN, 1'b1, 32'h00);
		check("pin held", {31'h0, serial_out_oe}, 32'h1);
		for (int n = 0; n < 400 && serial_out_oe; n++)
			@(posedge mclk);
		check("last frame", uartx_peer_inst.rxq[2], 32'h13C);
		check("pin released", {31'h0, serial_out_oe}, 32'h0);
		// receive errors, each with its enable off then on
		apb(ADDR_CONTROL_MAIN, 1'b1, 32'h2C);
		for (int e = 0; e < 3; e++)
			for (int en = 0; en < 2; en++)
			begin
				apb(ADDR_LINE_MODE, 1'b1, e == 2 ? 32'h2 : 32'h0);
				apb(ADDR_CONTROL_EXT, 1'b1, en << ebit[e]);
				repeat (e == 1 ? 2 : 1)
					uartx_peer_inst.send(e == 0 ? 9'h000 : 9'h001, e != 0);
				for (int n = 0; n < 100 && !rx_irq; n++)
					@(posedge mclk);
				check("error request", {31'h0, err_irq}, en);
				apb(ADDR_STATUS_FIRST, 1'b0, 32'h0);
				check("rx status", rdat & 32'h3F, 32'h20 | (1 << ebit[e]));
				rd("rx data", ADDR_DATA_PORT, e == 0 ? 32'h0 : 32'h1);
				apb(ADDR_STATUS_FIRST, 1'b0, 32'h0);
				check("flags cleared", rdat & 32'h3F, 32'h0);
			end
		// single-wire: direction bit decides pin ownership
		apb(ADDR_CONTROL_MAIN, 1'b1, 32'h08);
		apb(ADDR_LINE_MODE, 1'b1, 32'hA0);
		for (int k = 0; k < 2; k++)
		begin
			apb(ADDR_CONTROL_EXT, 1'b1, k << EXT_PIN_DIR);
			check("pin direction", {31'h0, serial_out_oe}, k);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
